// >>> dtc_pkg.sv
package dtc_pkg;
   // --------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // --------------------------------------------------------------
   localparam logic [7:0]  CTR0_HIGH_IDX = 8'h0c;
   localparam logic [7:0]  CTR0_LOW_IDX  = 8'h0d;
   localparam logic [7:0]  CTR0_CTRL_IDX = 8'h0e;
   localparam logic [7:0]  CTR1_HIGH_IDX = 8'h0f;
   localparam logic [7:0]  CTR1_LOW_IDX  = 8'h10;
   localparam logic [7:0]  CTR1_CTRL_IDX = 8'h11;
   localparam logic [7:0]  IRQ_IDX       = 8'h12;
   // --------------------------------------------------------------
   // control fields and counter values
   // --------------------------------------------------------------
   localparam int          EDGE_BIT      = 3;
   localparam int          RUN_BIT       = 4;
   localparam int          MODE_LSB      = 6;
   localparam logic [7:0]  CTRL_MASK     = 8'hd8;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [15:0] CNT_RESET     = 16'h0000;
   localparam logic [15:0] CNT_MAX       = 16'hffff;
   // --------------------------------------------------------------
   // timing
   // --------------------------------------------------------------
   localparam int          REF_CLK_HZ    = 20000000;
   localparam int          INSTR_DIV     = 4;
   localparam int          SLOW_HZ       = 32768;
   localparam logic [31:0] SLOW_INC      = 32'((64'(SLOW_HZ) << 32) / REF_CLK_HZ);

   typedef enum logic [1:0] {
      DTC_MODE_NONE  = 2'b00,
      DTC_MODE_EVENT = 2'b01,
      DTC_MODE_TIMER = 2'b10,
      DTC_MODE_PULSE = 2'b11
   } dtc_mode_t;
endpackage : dtc_pkg

// >>> dtc_counter.sv
`timescale 1ns/1ps
module dtc_counter
   import dtc_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // tick sources
   input  wire logic        int_tick,
   input  wire logic        pin_sync,
   // software access
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_high,
   input  wire logic        wr_low,
   input  wire logic        wr_ctrl,
   input  wire logic        rd_high,
   // state and overflow strobe
   output logic      [15:0] count,
   output logic      [7:0]  low_buf,
   output logic      [7:0]  ctrl,
   output logic             ovf
);
   logic [15:0] preload_reg;
   logic        pin_prev_reg;
   logic        active_reg;
   logic        rise;
   logic        fall;
   logic        edge_hit;
   logic        tick;
   logic        run;
   logic        edge_sel;
   dtc_mode_t   mode;

   assign run      = ctrl[RUN_BIT];
   assign edge_sel = ctrl[EDGE_BIT];
   assign mode     = dtc_mode_t'(ctrl[7:MODE_LSB]);
   assign rise     = pin_sync & ~pin_prev_reg;
   assign fall     = ~pin_sync & pin_prev_reg;
   assign edge_hit = edge_sel ? fall : rise;

   // --------------------------------------------------------------
   // tick selection
   // --------------------------------------------------------------
   always_comb begin
      case (mode)
         DTC_MODE_EVENT: tick = run & edge_hit;
         DTC_MODE_TIMER: tick = run & int_tick;
         DTC_MODE_PULSE: tick = run & active_reg & int_tick;
         default:        tick = 1'b0;
      endcase
   end
   assign ovf = tick & (count == CNT_MAX);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) pin_prev_reg <= 1'b0;
      else          pin_prev_reg <= pin_sync;
   end

   // --------------------------------------------------------------
   // pulse width measurement window
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         active_reg <= 1'b0;
      end else if (mode != DTC_MODE_PULSE || !run) begin
         active_reg <= 1'b0;
      end else if (!active_reg && (edge_sel ? rise : fall)) begin
         active_reg <= 1'b1;
      end else if (active_reg && (edge_sel ? fall : rise)) begin
         active_reg <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // control register
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= wdata & CTRL_MASK;
      end else if (mode == DTC_MODE_PULSE && active_reg && (edge_sel ? fall : rise)) begin
         ctrl[RUN_BIT] <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // preload and holding buffer
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         low_buf     <= 8'h00;
         preload_reg <= CNT_RESET;
      end else begin
         if (wr_low) low_buf <= wdata;
         else if (rd_high) low_buf <= count[7:0];
         if (wr_high) preload_reg <= {wdata, low_buf};
      end
   end

   // --------------------------------------------------------------
   // counter
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= CNT_RESET;
      end else if (wr_high && !run) begin
         count <= {wdata, low_buf};
      end else if (ovf) begin
         count <= preload_reg;
      end else if (tick) begin
         count <= count + 16'h0001;
      end
   end
endmodule : dtc_counter

// >>> dtc_top.sv
`timescale 1ns/1ps
module dtc_top
   import dtc_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // counter pins
   input  wire logic        ctr0_input_pin,
   input  wire logic        ctr1_input_pin,
   // requests
   output logic             ctr0_irq,
   output logic             ctr1_irq,
   output logic             wake_up
);
   logic [1:0]  sync0_reg;
   logic [1:0]  sync1_reg;
   logic [1:0]  div_reg;
   logic        instr_tick;
   logic [31:0] slow_acc_reg;
   logic        slow_tick;
   logic [1:0]  flag_reg;
   logic [1:0]  enable_reg;
   logic        wake_reg;
   logic [1:0]  ovf;
   logic [1:0]  ticks;
   logic [1:0]  pins;
   logic [15:0] count   [2];
   logic [7:0]  low_buf [2];
   logic [7:0]  ctrl    [2];
   logic        acc;
   logic        wr;
   logic        rd;
   logic        hit;
   logic [7:0]  idx;
   logic [7:0]  rdata_next;
   logic [31:0] prdata_reg;

   function automatic logic [7:0] reg_index(input logic [11:0] addr);
      reg_index = addr[9:2];
   endfunction : reg_index

   // --------------------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync0_reg <= 2'b00;
         sync1_reg <= 2'b00;
      end else begin
         sync0_reg <= {sync0_reg[0], ctr0_input_pin};
         sync1_reg <= {sync1_reg[0], ctr1_input_pin};
      end
   end
   assign pins = {sync1_reg[1], sync0_reg[1]};

   // --------------------------------------------------------------
   // internal count sources
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) div_reg <= 2'b00;
      else          div_reg <= div_reg + 2'b01;
   end
   assign instr_tick = (div_reg == 2'(INSTR_DIV - 1));

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         slow_acc_reg <= 32'h00000000;
         slow_tick    <= 1'b0;
      end else begin
         {slow_tick, slow_acc_reg} <= {1'b0, slow_acc_reg} + {1'b0, SLOW_INC};
      end
   end
   assign ticks = {slow_tick, instr_tick};

   // --------------------------------------------------------------
   // apb decode
   // --------------------------------------------------------------
   assign acc     = psel & penable;
   assign wr      = acc & pwrite & pstrb[0] & hit;
   // read strobe at setup: high byte and latched low byte from one count
   assign rd      = psel & ~penable & ~pwrite & hit;
   assign idx     = reg_index(paddr);
   assign pready  = 1'b1;
   assign hit     = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                    (idx >= CTR0_HIGH_IDX) && (idx <= IRQ_IDX);
   assign pslverr = acc & ~hit;
   assign prdata  = prdata_reg;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ctr
         localparam logic [7:0] HI = (g == 0) ? CTR0_HIGH_IDX : CTR1_HIGH_IDX;
         dtc_counter u_ctr (
            .ref_clk  (ref_clk),
            .reset_n  (reset_n),
            .int_tick (ticks[g]),
            .pin_sync (pins[g]),
            .wdata    (pwdata[7:0]),
            .wr_high  (wr && idx == HI),
            .wr_low   (wr && idx == HI + 8'h01),
            .wr_ctrl  (wr && idx == HI + 8'h02),
            .rd_high  (rd && idx == HI),
            .count    (count[g]),
            .low_buf  (low_buf[g]),
            .ctrl     (ctrl[g]),
            .ovf      (ovf[g])
         );
      end
   endgenerate

   // --------------------------------------------------------------
   // read mux
   // --------------------------------------------------------------
   always_comb begin
      case (idx)
         CTR0_HIGH_IDX: rdata_next = count[0][15:8];
         CTR0_LOW_IDX:  rdata_next = low_buf[0];
         CTR0_CTRL_IDX: rdata_next = ctrl[0];
         CTR1_HIGH_IDX: rdata_next = count[1][15:8];
         CTR1_LOW_IDX:  rdata_next = low_buf[1];
         CTR1_CTRL_IDX: rdata_next = ctrl[1];
         IRQ_IDX:       rdata_next = {4'h0, enable_reg, flag_reg};
         default:       rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)            prdata_reg <= 32'h00000000;
      else if (rd)             prdata_reg <= {24'h000000, rdata_next};
      else if (psel && !penable && !pwrite) prdata_reg <= 32'h00000000;
   end

   // --------------------------------------------------------------
   // flags, enables, wake-up
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_reg   <= 2'b00;
         enable_reg <= 2'b00;
      end else begin
         if (wr && idx == IRQ_IDX) begin
            enable_reg <= pwdata[3:2];
            flag_reg   <= (flag_reg & ~pwdata[1:0]) | ovf;
         end else begin
            flag_reg   <= flag_reg | ovf;
         end
      end
   end
   assign ctr0_irq = flag_reg[0] & enable_reg[0];
   assign ctr1_irq = flag_reg[1] & enable_reg[1];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) wake_reg <= 1'b0;
      else          wake_reg <= |ovf;
   end
   assign wake_up = wake_reg;
endmodule : dtc_top

// >>> dtc_top_properties.sv
`timescale 1ns/1ps
module dtc_top_checker
   import dtc_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        reset_n,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // requests
   input wire logic        ctr0_irq,
   input wire logic        ctr1_irq,
   input wire logic        wake_up
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic acc;
   logic hit;
   logic ctl;
   assign acc = psel && penable;
   assign hit = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 && paddr[9:2] >= CTR0_HIGH_IDX
                && paddr[9:2] <= IRQ_IDX;
   assign ctl = paddr[9:2] == CTR0_CTRL_IDX || paddr[9:2] == CTR1_CTRL_IDX;
   a_ready_now: assert property (acc |-> pready)
      else $error("ready low in access");
   a_err_unmapped: assert property (acc && !hit |-> pslverr)
      else $error("no error on unmapped");
   a_err_mapped: assert property (acc && hit |-> !pslverr)
      else $error("error on mapped");
   a_read_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_ctrl_unused: assert property (acc && !pwrite && hit && ctl |-> prdata[2:0] == 3'h0
                                   && !prdata[5])
      else $error("unused control bits set");
   a_hold_data: assert property ($past(acc) && !psel |-> $stable(prdata))
      else $error("read data moved");
   a_wake_irq: assert property (($rose(ctr0_irq) || $rose(ctr1_irq)) && !$past(acc && pwrite)
                                |-> ##[0:1] wake_up)
      else $error("no wake on overflow");
   a_mask_irq: assert property (acc && pwrite && hit && pstrb[0] && paddr[9:2] == IRQ_IDX
                                && pwdata[3:2] == 2'h0 |=> !ctr0_irq && !ctr1_irq)
      else $error("masked request seen");
   c_wake: cover property (wake_up);
   c_refused: cover property (acc && !hit);
   c_irq: cover property (ctr0_irq);
endmodule : dtc_top_checker

bind dtc_top dtc_top_checker u_dtc_top_checker (.ref_clk, .reset_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ctr0_irq, .ctr1_irq, .wake_up);

// >>> dtc_pin_source.sv
`timescale 1ns/1ps
module dtc_pin_source (
   // clock
   input wire logic ref_clk,
   // pin
   output logic     pin
);
   initial pin = 1'b0;
   // level held whole cycles so the synchroniser sees it
   task automatic hold(input logic lvl, input int n);
      pin <= lvl;
      repeat (n) @(posedge ref_clk);
   endtask : hold
endmodule : dtc_pin_source

// >>> test_dual_timer_event_counter.sv
`timescale 1ns/1ps
module test_dual_timer_event_counter import dtc_pkg::*;;
   logic        ref_clk, reset_n, psel, penable, pwrite, pin0, pin1, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        pready, pslverr, irq0, irq1, wake, wake_seen;
   logic [7:0]  rd;
   logic [15:0] v, w;
   int          mismatches, num_checks;

   dtc_top u_dtc_top (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .ctr0_input_pin(pin0), .ctr1_input_pin(pin1),
      .ctr0_irq(irq0), .ctr1_irq(irq1), .wake_up(wake));
   dtc_pin_source u_src0 (.ref_clk, .pin(pin0));
   dtc_pin_source u_src1 (.ref_clk, .pin(pin1));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (wake) wake_seen <= 1'b1;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   // ----------------------------
   // apb master
   // ----------------------------
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata[7:0];
      err = pslverr;
      if (n >= 50) begin
         check(16'h0, 16'h1);
         final_report();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic read16(input int k, output logic [15:0] r);
      apb(1'b0, CTR0_HIGH_IDX + 8'(3 * k), 8'h0);
      r[15:8] = rd;
      apb(1'b0, CTR0_LOW_IDX + 8'(3 * k), 8'h0);
      r[7:0] = rd;
   endtask : read16
   task automatic load16(input int k, input logic [15:0] d);
      apb(1'b1, CTR0_LOW_IDX + 8'(3 * k), d[7:0]);
      apb(1'b1, CTR0_HIGH_IDX + 8'(3 * k), d[15:8]);
   endtask : load16
   // ----------------------------
   // scenarios
   // ----------------------------
   task automatic t_regs;
      apb(1'b1, CTR0_CTRL_IDX, 8'hff);
      apb(1'b0, CTR0_CTRL_IDX, 8'h0);
      check(rd, 8'hd8);
      apb(1'b1, CTR0_CTRL_IDX, 8'h00);
      apb(1'b0, 8'h13, 8'h0);
      check(err, 1'b1);
      load16(0, 16'h1234);
      read16(0, v);
      check(v, 16'h1234);
      apb(1'b1, CTR0_LOW_IDX, 8'h56);
      read16(0, v);
      check(v, 16'h1234);
      apb(1'b1, CTR0_LOW_IDX, 8'h77);
      apb(1'b0, CTR0_LOW_IDX, 8'h0);
      check(rd, 8'h77);
   endtask : t_regs
   task automatic t_timer;
      load16(0, 16'h0);
      apb(1'b1, CTR0_CTRL_IDX, 8'h90);
      repeat (400) @(posedge ref_clk);
      apb(1'b1, CTR0_CTRL_IDX, 8'h80);
      read16(0, v);
      check(v >= 16'd99 && v <= 16'd102, 1'b1);
      repeat (100) @(posedge ref_clk);
      read16(0, w);
      check(w, v);
   endtask : t_timer
   task automatic t_ovf;
      load16(0, 16'hfff0);
      apb(1'b1, IRQ_IDX, 8'h04);
      wake_seen = 1'b0;
      apb(1'b1, CTR0_CTRL_IDX, 8'h90);
      repeat (80) @(posedge ref_clk);
      apb(1'b0, CTR0_CTRL_IDX, 8'h0);
      check(rd, 8'h90);
      check(irq0, 1'b1);
      check(wake_seen, 1'b1);
      apb(1'b1, CTR0_CTRL_IDX, 8'h80);
      read16(0, v);
      check(v >= 16'hfff3 && v <= 16'hfff7, 1'b1);
      apb(1'b1, IRQ_IDX, 8'h00);
      check(irq0, 1'b0);
      apb(1'b1, IRQ_IDX, 8'h04);
      check(irq0, 1'b1);
      apb(1'b1, IRQ_IDX, 8'h05);
      check(irq0, 1'b0);
   endtask : t_ovf
   task automatic t_reload;
      apb(1'b1, IRQ_IDX, 8'h0c);
      load16(0, 16'hfff0);
      load16(1, 16'hfffe);
      apb(1'b1, CTR1_CTRL_IDX, 8'h10);
      apb(1'b1, CTR0_CTRL_IDX, 8'h90);
      load16(0, 16'h8000);
      apb(1'b1, CTR0_LOW_IDX, 8'h55);
      read16(0, v);
      check(v >= 16'hfff1 && v <= 16'hfff4, 1'b1);
      repeat (80) @(posedge ref_clk);
      apb(1'b1, CTR0_CTRL_IDX, 8'h80);
      check(irq0, 1'b1);
      read16(0, v);
      check(v >= 16'h8007 && v <= 16'h800a, 1'b1);
      repeat (700) @(posedge ref_clk);
      read16(1, v);
      check(v, 16'hfffe);
      apb(1'b1, CTR1_CTRL_IDX, 8'h90);
      repeat (1500) @(posedge ref_clk);
      check(irq1, 1'b1);
      apb(1'b1, CTR1_CTRL_IDX, 8'h80);
      read16(1, v);
      check(v >= 16'hfffe, 1'b1);
      apb(1'b1, IRQ_IDX, 8'h03);
      check(irq1, 1'b0);
   endtask : t_reload
   task automatic t_event;
      for (int e = 0; e < 2; e++) begin
         load16(0, 16'h0);
         apb(1'b1, CTR0_CTRL_IDX, 8'h50 | 8'(e << 3));
         for (int i = 0; i < 5; i++) begin
            u_src0.hold(1'b1, 4);
            u_src0.hold(1'b0, 4);
         end
         u_src0.hold(1'b1, 4);
         read16(0, v);
         check(v, 16'd6 - 16'(e));
         apb(1'b1, CTR0_CTRL_IDX, 8'h40);
         u_src0.hold(1'b0, 4);
      end
   endtask : t_event
   task automatic t_pulse;
      load16(1, 16'h0);
      u_src1.hold(1'b1, 4);
      apb(1'b1, CTR1_CTRL_IDX, 8'hd8);
      u_src1.hold(1'b1, 1000);
      read16(1, v);
      check(v, 16'h0);
      u_src1.hold(1'b0, 8);
      u_src1.hold(1'b1, 3000);
      u_src1.hold(1'b0, 8);
      apb(1'b0, CTR1_CTRL_IDX, 8'h0);
      check(rd, 8'hc8);
      read16(1, v);
      check(v >= 16'd4 && v <= 16'd5, 1'b1);
      u_src1.hold(1'b1, 3000);
      u_src1.hold(1'b0, 8);
      read16(1, w);
      check(w, v);
   endtask : t_pulse

   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'h1;
      wake_seen = 1'b0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_timer();
      t_ovf();
      t_reload();
      t_event();
      t_pulse();
      final_report();
   end
endmodule : test_dual_timer_event_counter
